/* File: rtl/emcc_pkg.sv */
// shared constants and types of the common memory control block
package emcc_pkg;
    localparam int          NUM_SPACES  = 4;
    localparam int          NUM_LANES   = 8;
    localparam int          SPACE_MSB   = 31;
    localparam int          SPACE_LSB   = 28;
    localparam int          CNT_W       = 8;
    // memory width / access size codes: 0=8, 1=16, 2=32, 3=64 bits
    localparam logic [1:0]  WIDTH_8     = 2'h0;
    localparam logic [1:0]  WIDTH_64    = 2'h3;
    // lane masks per width code, 8 bits each
    localparam logic [31:0] LANE_TABLE  = 32'hFF0F0301;
    // low address bit masks per width code, 3 bits each
    localparam logic [11:0] OFS_TABLE   = 12'hEC8;
    localparam logic [3:0]  SEL_OFF_N   = 4'hF;
    localparam logic [7:0]  BE_OFF_N    = 8'hFF;
    localparam logic [7:0]  BE_ALL      = 8'hFF;
    localparam logic [7:0]  BE_NONE     = 8'h00;
    typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_FLOAT, ST_HOLD} emcc_state_t;
endpackage

/* File: rtl/emcc_ctrl.sv */
// common control pins of the wide memory interface: selects, byte lanes, transfer strobe, hold
`timescale 1ns/1ps
// Contract
// - select chosen from word address bits 28-31
// - at most one select active at once
// - byte enables decoded from low address bits on writes and sdram reads; other reads enable every lane of the width
// - decoded bits and lanes follow memory width
// - writes enable only lanes carrying valid data
// - byte enables usable as sdram data mask
// - strobe for direct peripheral-to-peripheral transfer
// - device answers hold with grant output
// - bus request output shows pending accesses
module emcc_ctrl
    import emcc_pkg::*;
#(
    parameter int          ACC_CYCLES = 4,
    parameter logic [15:0] SPACE_TAGS = 16'hBA98
) (
    // clock and reset
    input  wire logic       CLK,
    input  wire logic       SYS_RST,
    // space configuration
    input  wire logic [7:0] SPACE_WIDTH,
    input  wire logic [3:0] SPACE_SDRAM,
    // access request from the core side
    input  wire logic       REQ_VALID,
    input  wire logic [31:0] REQ_ADDR,
    input  wire logic [1:0] REQ_SIZE,
    input  wire logic       REQ_WRITE,
    input  wire logic [7:0] REQ_WMASK,
    input  wire logic       REQ_PDT,
    output logic            REQ_ACCEPT,
    output logic            REQ_DONE,
    output logic            REQ_ERR,
    // memory control pins
    output logic [3:0]      SPACE_SELECT_N,
    output logic [7:0]      BYTE_LANE_ENABLE_N,
    output logic            PERIPH_DIRECT_XFER_N,
    output logic            BUS_OE,
    // arbitration pins
    input  wire logic       HOST_BUS_REQUEST_IN,
    output logic            HOST_BUS_GRANT_OUT,
    output logic            PENDING_ACCESS_REQUEST
);
    emcc_state_t      st;
    emcc_state_t      next_st;
    logic [CNT_W-1:0] cnt;
    logic             hold_s1;
    logic             hold_s2;
    logic [3:0]       hit;
    logic [3:0]       hit_first;
    logic [1:0]       idx;
    logic [1:0]       wcode;
    logic             sdram;
    logic [7:0]       lane_mask;
    logic [7:0]       size_mask;
    logic [2:0]       ofs;
    logic [7:0]       decoded;
    logic [7:0]       be_on;
    logic             idle_free;
    logic             take;
    logic             refuse;
    logic             acc_end;
    logic [CNT_W-1:0] next_cnt;

    // space match on the top address nibble
    genvar g;
    generate
        for (g = 0; g < NUM_SPACES; g++) begin : g_hit
            assign hit[g] = REQ_ADDR[SPACE_MSB:SPACE_LSB] == SPACE_TAGS[4*g +: 4];
        end
    endgenerate
    assign hit_first = hit & ~(hit - 4'h1);

    always_comb begin
        idx = 2'h0;
        for (int i = NUM_SPACES - 1; i >= 0; i--) begin
            if (hit[i]) begin
                idx = 2'(i);
            end
        end
    end

    // byte lane decode by memory width and access size
    assign wcode     = SPACE_WIDTH[2*idx +: 2];
    assign sdram     = SPACE_SDRAM[idx];
    assign lane_mask = LANE_TABLE[8*wcode +: 8];
    assign size_mask = LANE_TABLE[8*REQ_SIZE +: 8];
    assign ofs       = REQ_ADDR[2:0] & OFS_TABLE[3*wcode +: 3];
    assign decoded   = (size_mask << ofs) & lane_mask;
    assign be_on     = REQ_WRITE ? (decoded & REQ_WMASK) :
                       (sdram ? decoded : lane_mask);

    // request handling
    assign idle_free = (st == ST_IDLE) && !hold_s2;
    assign take      = idle_free && REQ_VALID && (hit != 4'h0);
    assign refuse    = idle_free && REQ_VALID && (hit == 4'h0);
    assign acc_end   = (st == ST_ACCESS) && (cnt == '0);
    assign next_cnt  = take ? CNT_W'(ACC_CYCLES - 1) :
                       ((cnt != '0) ? cnt - CNT_W'(1) : cnt);

    always_comb begin
        next_st = st;
        case (st)
            ST_IDLE: begin
                if (hold_s2) begin
                    next_st = ST_FLOAT;
                end else if (take) begin
                    next_st = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (acc_end) begin
                    next_st = ST_IDLE;
                end
            end
            ST_FLOAT: begin
                next_st = hold_s2 ? ST_HOLD : ST_IDLE;
            end
            ST_HOLD: begin
                if (!hold_s2) begin
                    next_st = ST_IDLE;
                end
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
    end

    // host hold request synchroniser
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            hold_s1 <= 1'b0;
            hold_s2 <= 1'b0;
        end else begin
            hold_s1 <= HOST_BUS_REQUEST_IN;
            hold_s2 <= hold_s1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            st  <= ST_IDLE;
            cnt <= '0;
        end else begin
            st  <= next_st;
            cnt <= next_cnt;
        end
    end

    // pin outputs
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SPACE_SELECT_N       <= SEL_OFF_N;
            BYTE_LANE_ENABLE_N   <= BE_OFF_N;
            PERIPH_DIRECT_XFER_N <= 1'b1;
        end else if (take) begin
            SPACE_SELECT_N       <= ~hit_first;
            BYTE_LANE_ENABLE_N   <= ~be_on;
            PERIPH_DIRECT_XFER_N <= ~REQ_PDT;
        end else if (acc_end || (st != ST_ACCESS)) begin
            SPACE_SELECT_N       <= SEL_OFF_N;
            BYTE_LANE_ENABLE_N   <= BE_OFF_N;
            PERIPH_DIRECT_XFER_N <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            BUS_OE                 <= 1'b1;
            HOST_BUS_GRANT_OUT     <= 1'b0;
            PENDING_ACCESS_REQUEST <= 1'b0;
            REQ_ACCEPT             <= 1'b0;
            REQ_DONE               <= 1'b0;
            REQ_ERR                <= 1'b0;
        end else begin
            BUS_OE                 <= (next_st == ST_IDLE) || (next_st == ST_ACCESS);
            HOST_BUS_GRANT_OUT     <= (next_st == ST_HOLD);
            PENDING_ACCESS_REQUEST <= REQ_VALID && !take && !refuse;
            REQ_ACCEPT             <= take;
            REQ_DONE               <= acc_end;
            REQ_ERR                <= refuse;
        end
    end

    // checks
    sequence s_take;
        take;
    endsequence
    sequence s_hold_wait;
        (st == ST_IDLE) && hold_s2;
    endsequence

    a_sel_onehot: assert property (@(posedge CLK) disable iff (SYS_RST)
        $onehot0(~SPACE_SELECT_N))
        else $error("more than one space select active");
    a_sel_decode: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_take |=> (~SPACE_SELECT_N == $past(hit_first)) && (SPACE_SELECT_N != SEL_OFF_N))
        else $error("space select does not match address");
    a_be_width: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_take |=> ((~BYTE_LANE_ENABLE_N & ~$past(lane_mask)) == BE_NONE))
        else $error("byte enable outside memory width");
    a_be_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_take ##0 REQ_WRITE |=> ((~BYTE_LANE_ENABLE_N & ~$past(REQ_WMASK)) == BE_NONE))
        else $error("write enable on lane without data");
    a_be_mask: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_take ##0 (sdram && !REQ_WRITE) |=> (~BYTE_LANE_ENABLE_N == $past(decoded)))
        else $error("sdram read mask not decoded");
    a_pdt_strobe: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_take ##0 REQ_PDT |=> !PERIPH_DIRECT_XFER_N ##1 (!PERIPH_DIRECT_XFER_N || REQ_DONE))
        else $error("peripheral transfer strobe missing");
    a_grant_answer: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_hold_wait ##1 hold_s2 |-> ##1 HOST_BUS_GRANT_OUT)
        else $error("hold request not granted");
    a_grant_float: assert property (@(posedge CLK) disable iff (SYS_RST)
        HOST_BUS_GRANT_OUT |-> !BUS_OE && (SPACE_SELECT_N == SEL_OFF_N) && $past(!BUS_OE))
        else $error("grant while interface still driven");
    a_busreq_pend: assert property (@(posedge CLK) disable iff (SYS_RST)
        REQ_VALID && (st == ST_HOLD) |=> PENDING_ACCESS_REQUEST)
        else $error("pending access not signalled");
endmodule

/* File: verif/emcc_host.sv */
// host model that asks for the memory bus on the hold request pin
`timescale 1ns/1ps
module emcc_host (
    // clock
    input  wire logic CLK,
    // bench control and grant seen
    input  wire logic want,
    input  wire logic grant,
    // hold request level
    output logic      req
);
    // once raised, the request stays up until the grant has been seen
    always_ff @(posedge CLK) req <= want || ((req === 1'b1) && (grant !== 1'b1));
endmodule

/* File: verif/ext_mem_common_control_tb.sv */
// self-checking bench of the common memory control block
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
module ext_mem_common_control_tb;
    import emcc_pkg::*;
    localparam int ACC = 4;
    int check_count = 0, bad_count = 0;
    logic CLK = 0, SYS_RST = 1, REQ_VALID = 0, REQ_WRITE = 0, REQ_PDT = 0, want = 0;
    logic [31:0] REQ_ADDR = '0;
    logic [1:0] REQ_SIZE = '0;
    logic [7:0] REQ_WMASK = '0, SPACE_WIDTH = 8'h27;
    logic [3:0] SPACE_SDRAM = 4'h4, SEL_N;
    logic [7:0] BE_N;
    logic ACC_OK, DONE, ERR, PDT_N, OE, GRANT, PEND, HREQ;
    always #2 CLK = ~CLK;
    emcc_host host (.CLK(CLK), .want(want), .grant(GRANT), .req(HREQ));
    emcc_ctrl #(.ACC_CYCLES(ACC)) uut (.CLK(CLK), .SYS_RST(SYS_RST),
        .SPACE_WIDTH(SPACE_WIDTH), .SPACE_SDRAM(SPACE_SDRAM), .REQ_VALID(REQ_VALID),
        .REQ_ADDR(REQ_ADDR), .REQ_SIZE(REQ_SIZE), .REQ_WRITE(REQ_WRITE),
        .REQ_WMASK(REQ_WMASK), .REQ_PDT(REQ_PDT), .REQ_ACCEPT(ACC_OK), .REQ_DONE(DONE),
        .REQ_ERR(ERR), .SPACE_SELECT_N(SEL_N), .BYTE_LANE_ENABLE_N(BE_N),
        .PERIPH_DIRECT_XFER_N(PDT_N), .BUS_OE(OE), .HOST_BUS_REQUEST_IN(HREQ),
        .HOST_BUS_GRANT_OUT(GRANT), .PENDING_ACCESS_REQUEST(PEND));
    function automatic logic [7:0] exp_be(logic [31:0] a, logic [1:0] sz, logic wr,
                                          logic [7:0] wm);
        logic [1:0] w;
        logic [7:0] d;
        w = SPACE_WIDTH[2*a[29:28] +: 2];
        d = (8'((1 << (1 << sz)) - 1) << (a[2:0] & OFS_TABLE[3*w +: 3])) & LANE_TABLE[8*w +: 8];
        return ~(wr ? d & wm : (SPACE_SDRAM[a[29:28]] ? d : LANE_TABLE[8*w +: 8]));
    endfunction
    task automatic access(logic [31:0] a, logic [1:0] sz, logic wr, logic [7:0] wm,
                          logic pdt, logic [3:0] sel);
        int n;
        logic [7:0] be;
        n = 0;
        be = (sel == SEL_OFF_N) ? BE_OFF_N : exp_be(a, sz, wr, wm);
        @(posedge CLK) {REQ_VALID, REQ_ADDR, REQ_SIZE, REQ_WRITE, REQ_WMASK, REQ_PDT} <=
            {1'b1, a, sz, wr, wm, pdt};
        do begin @(negedge CLK); n++; end while (ACC_OK !== 1'b1 && ERR !== 1'b1 && n < 20);
        `CHK(ERR, sel == SEL_OFF_N)
        for (int i = 0; i <= ACC; i++) begin
            `CHK(SEL_N, (i < ACC) ? sel : SEL_OFF_N)
            `CHK(BE_N, (i < ACC) ? be : BE_OFF_N)
            `CHK(PDT_N, !(pdt && i < ACC && sel != SEL_OFF_N))
            `CHK(DONE, i == ACC && sel != SEL_OFF_N)
            @(posedge CLK) REQ_VALID <= 1'b0;
            @(negedge CLK);
        end
    endtask
    task automatic t_reset;
        repeat (3) @(negedge CLK);
        `CHK({SEL_N, BE_N, PDT_N, OE, GRANT, PEND}, {SEL_OFF_N, BE_OFF_N, 4'hC})
        @(posedge CLK) SYS_RST <= 1'b0;
        $display("test reset done");
    endtask
    task automatic t_write;
        access(32'h8000_0002, 2'h1, 1'b1, 8'h0C, 1'b0, 4'hE);
        access(32'h8000_0000, 2'h3, 1'b1, 8'hFF, 1'b0, 4'hE);
        access(32'h9000_0001, 2'h0, 1'b1, 8'h02, 1'b1, 4'hD);
        access(32'hB000_0006, 2'h1, 1'b1, 8'h03, 1'b0, 4'h7);
        $display("test write done");
    endtask
    task automatic t_read;
        access(32'h9000_0005, 2'h0, 1'b0, 8'h00, 1'b0, 4'hD);
        access(32'hA000_0003, 2'h0, 1'b0, 8'h00, 1'b1, 4'hB);
        access(32'hB000_0004, 2'h2, 1'b0, 8'h00, 1'b0, 4'h7);
        access(32'h1000_0000, 2'h0, 1'b0, 8'h00, 1'b1, 4'hF);
        $display("test read done");
    endtask
    task automatic t_hold;
        int n;
        n = 0;
        @(posedge CLK) {REQ_VALID, REQ_ADDR, want} <= {1'b1, 32'h8000_0000, 1'b1};
        repeat (2) @(posedge CLK);
        REQ_VALID <= 1'b0;
        do begin
            @(negedge CLK);
            n++;
            `CHK(!OE && SEL_N !== SEL_OFF_N, 1'b0)
        end while (OE !== 1'b0 && n < 30);
        `CHK(GRANT, 1'b0)
        @(negedge CLK) `CHK(GRANT, 1'b1)
        @(posedge CLK) REQ_VALID <= 1'b1;
        repeat (3) @(negedge CLK);
        `CHK({PEND, ACC_OK, OE}, 3'h4)
        @(posedge CLK) want <= 1'b0;
        n = 0;
        do begin @(negedge CLK); n++; end while (GRANT !== 1'b0 && n < 30);
        `CHK({OE, ACC_OK}, 2'h2)
        n = 0;
        do begin @(negedge CLK); n++; end while (ACC_OK !== 1'b1 && n < 10);
        `CHK(SEL_N, 4'hE)
        @(posedge CLK) REQ_VALID <= 1'b0;
        repeat (ACC + 2) @(negedge CLK);
        `CHK({PEND, SEL_N}, {1'b0, SEL_OFF_N})
        $display("test hold done");
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #8000;
        bad_count++;
        end_sim();
    end
    initial begin
        t_reset();
        t_write();
        t_read();
        t_hold();
        end_sim();
    end
endmodule
